// ===== pkg/dm_map_defines.svh
// offsets, field positions, reset values and timing counts of the data-word map
`ifndef DM_MAP_DEFINES_SVH
`define DM_MAP_DEFINES_SVH

// register indices, byte address is four times the index
`define REG_CTRL          8'h00
`define REG_EXT_SIZE      8'h01
`define REG_STATUS        8'h02
`define REG_UNIT_SEL      8'h03
`define REG_UNIT_CFG      8'h04
`define REG_PEAK_SCAN     8'h1A
`define REG_PRESENT_SCAN  8'h1B

// address windows on the bus
`define WIN_REGS          2'h0
`define WIN_DATA          2'h1
`define WIN_INDIRECT      2'h2

// control fields
`define CTRL_TOOL_BIT     0
`define CTRL_BITOP_BIT    1
`define CTRL_STARTCP_BIT  2
`define CTRL_CLEAR_BIT    3
`define CTRL_COPY_BIT     4
`define CTRL_RESET        3'h0
`define EXT_SIZE_RESET    2'h0

// setup word fields
`define SETUP_UNITS16_BIT 0
`define SETUP_HIBASE_BIT  1

// data-word addresses
`define DM_WORDS          14'h2710
`define DM_LAST           14'h270F
`define DM_DEF_BASE       14'h03E8
`define DM_EXT_BASE       14'h1B58
`define DM_EXT_STEP       14'h03E8
`define DM_COPY_LAST      14'h03E7
`define DM_HIST_PTR       14'h1770
`define DM_HIST_PTR_MAX   16'h000A
`define DM_SYS_WORD       14'h178F
`define DM_RESV_FIRST     14'h17D4
`define DM_SYS_FIRST      14'h1800
`define DM_SETUP_UNITS    14'h19CA
`define DM_NONE_FIRST     14'h1A00
`define DM_UNIT_SPAN      14'h0064
`define DM_UNITS_FEW      5'h0A
`define DM_UNITS_MANY     5'h10

// scan time, unit of 0.1 ms at a 4 ns clock
`define CLK_PERIOD_NS     4
`define SCAN_UNIT_NS      100000
`define SCAN_TICK_CYCLES  (`SCAN_UNIT_NS / `CLK_PERIOD_NS)
`define BCD_MAX           16'h9999

`endif

// ===== pkg/dm_map_pkg.sv
// types shared by the data-word map design
package dm_map_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACC,
    ST_IND,
    ST_RESP,
    ST_CLEAR,
    ST_COPY_RD,
    ST_COPY_WR
  } state_t;

  typedef enum logic [1:0] {
    K_REG,
    K_DATA,
    K_IND
  } kind_t;
endpackage

// ===== hdl/data_word_store.sv
// single-port data-word memory with registered read data
`timescale 1ns/10ps
module data_word_store #(
  parameter int DEPTH = 10000,
  parameter int AW    = 14,
  parameter int DW    = 16
) (
  input  wire logic          hclk,
  input  wire logic          en,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);
  // no reset on the array: contents survive a reset, as battery-backed words do
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge hclk) begin
    if (en) begin
      if (we) begin
        mem[addr] <= wdata;
      end else begin
        rdata <= mem[addr];
      end
    end
  end
endmodule

// ===== hdl/scan_time_bcd.sv
// peak and present scan time as four bcd digits of 0.1 ms
`timescale 1ns/10ps
`include "dm_map_defines.svh"
module scan_time_bcd #(
  parameter int TICK_CYCLES = `SCAN_TICK_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        run_start,
  input  wire logic        scan_end,
  output logic      [15:0] peak_bcd,
  output logic      [15:0] present_bcd
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  logic [TW-1:0] tick_cnt_reg;
  logic [15:0]   run_bcd_reg;
  logic          tick;

  // saturates at 999.9 ms instead of wrapping to a short time
  function automatic logic [15:0] bcd_inc(input logic [15:0] v);
    logic [15:0] r;
    logic        c;
    r = v;
    c = 1'b1;
    if (v != `BCD_MAX) begin
      for (int i = 0; i < 4; i++) begin
        if (c) begin
          if (r[4*i +: 4] == 4'h9) begin
            r[4*i +: 4] = 4'h0;
          end else begin
            r[4*i +: 4] = r[4*i +: 4] + 4'h1;
            c = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  assign tick = (tick_cnt_reg == TW'(TICK_CYCLES - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_reg <= '0;
      run_bcd_reg  <= 16'h0000;
      present_bcd  <= 16'h0000;
      peak_bcd     <= 16'h0000;
    end else if (run_start) begin
      tick_cnt_reg <= '0;
      run_bcd_reg  <= 16'h0000;
      present_bcd  <= 16'h0000;
      peak_bcd     <= 16'h0000;
    end else if (scan_end) begin
      tick_cnt_reg <= '0;
      run_bcd_reg  <= 16'h0000;
      present_bcd  <= run_bcd_reg;
      if (run_bcd_reg > peak_bcd) begin
        peak_bcd <= run_bcd_reg;
      end
    end else begin
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + TW'(1);
      if (tick) begin
        run_bcd_reg <= bcd_inc(run_bcd_reg);
      end
    end
  end
endmodule

// ===== hdl/data_memory_map_access.sv
// data-word map: region decode, access policy, indirect, extended words, scan time
//
// Notes on behaviour
// - peak word holds longest scan since run
// - present word holds the latest scan time
// - both are bcd 0.1 ms; present refreshed every scan, peak only by a longer scan
// - program may write words 0 to 6143
// - words 6144 to 6655 written by tool only
// - bit-operand access to data words refused
// - data words survive power loss
// - word 6031 system only, program may not write
// - indirect operand points to actual data word
// - extended words never take part in indirect
// - extended size 0 to 3 K from 7000
// - size change only after memory clear
// - extended words written by tool only
// - copy extended words into 1000 to 1999
// - extended words kept with the program
// - setup word picks unit count and base
// - unit block starts at base plus 100n
// - unassigned unit words act as ordinary words
// - history pointer 6000, records 6001 to 6030
`timescale 1ns/10ps
`include "dm_map_defines.svh"
module data_memory_map_access #(
  parameter int TICK_CYCLES = `SCAN_TICK_CYCLES,
  parameter int DEPTH       = 10000
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  input  wire logic        run_start,
  input  wire logic        scan_end
);
  ////////////////////////////////////////////////////////////////////////////////
  // state
  dm_map_pkg::state_t state_reg;
  dm_map_pkg::state_t state_next;
  dm_map_pkg::kind_t  kind_reg;
  logic [13:0] word_reg;
  logic [7:0]  idx_reg;
  logic        write_reg;
  logic [15:0] wdata_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic        resp_mem_reg;
  logic        resp_mem_next;
  logic        ret_bus_reg;
  logic [13:0] eng_cnt_reg;
  logic [2:0]  ctrl_reg;
  logic [1:0]  ext_size_reg;
  logic [3:0]  unit_sel_reg;
  logic [1:0]  unit_cfg_reg;
  logic        viol_reg;
  logic        cleared_reg;
  logic        start_copy_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // decode
  logic        take;
  logic        tool;
  logic        bitop;
  logic [13:0] ext_top;
  logic [15:0] mem_rdata;
  logic [13:0] target;
  logic        ptr_bcd_ok;
  logic        target_ok;
  logic        op_ok;
  logic        reg_wr;
  logic        mem_en;
  logic        mem_we;
  logic [13:0] mem_addr;
  logic [15:0] mem_wdata;
  logic        viol_set;
  logic        viol_clr;
  logic        eng_last;
  logic        unit_valid;
  logic [13:0] unit_start;
  logic [31:0] reg_rdata;
  logic [15:0] peak_scan_time;
  logic [15:0] present_scan_time;

  // all words below 6656 exist; extended words only up to the allocated top
  function automatic logic rd_ok(input logic [13:0] w, input logic [13:0] top);
    return (w < `DM_NONE_FIRST) || ((w >= `DM_EXT_BASE) && (w <= top));
  endfunction

  function automatic logic wr_ok(input logic [13:0] w, input logic [13:0] top,
                                 input logic t, input logic [15:0] d);
    logic ok;
    ok = 1'b1;
    if (w >= `DM_EXT_BASE) begin
      ok = t && (w <= top);
    end else if (w >= `DM_NONE_FIRST) begin
      ok = 1'b0;
    end else if (w >= `DM_SYS_FIRST) begin
      ok = t;
    end else if (w == `DM_SYS_WORD) begin
      ok = t;
    end else if (w == `DM_HIST_PTR) begin
      ok = (d <= `DM_HIST_PTR_MAX);
    end
    return ok;
  endfunction

  // four bcd digits to a word number; an invalid digit gives an invalid pointer
  function automatic logic [14:0] bcd_to_word(input logic [15:0] b);
    logic ok;
    ok = (b[15:12] < 4'hA) && (b[11:8] < 4'hA) && (b[7:4] < 4'hA) && (b[3:0] < 4'hA);
    return {ok, 14'(b[15:12]) * 14'h03E8 + 14'(b[11:8]) * 14'h0064 + 14'(b[7:4]) * 14'h000A
                + 14'(b[3:0])};
  endfunction

  function automatic logic [13:0] unit_base(input logic [3:0] u, input logic hi);
    return (hi ? `DM_EXT_BASE : `DM_DEF_BASE) + 14'(u * `DM_UNIT_SPAN);
  endfunction

  assign take       = hsel && htrans[1] && hready;
  assign tool       = ctrl_reg[`CTRL_TOOL_BIT];
  assign bitop      = ctrl_reg[`CTRL_BITOP_BIT];
  assign ext_top    = `DM_EXT_BASE + 14'(ext_size_reg * `DM_EXT_STEP) - 14'h0001;
  assign {ptr_bcd_ok, target} = bcd_to_word(mem_rdata);
  // pointer must be valid bcd and name an ordinary word, never an extended one
  assign target_ok  = ptr_bcd_ok && (target < `DM_NONE_FIRST);
  assign op_ok      = !bitop && (word_reg < `DM_NONE_FIRST);
  assign reg_wr     = (state_reg == dm_map_pkg::ST_ACC) && (kind_reg == dm_map_pkg::K_REG)
                      && write_reg;
  assign eng_last   = (state_reg == dm_map_pkg::ST_CLEAR) ? (eng_cnt_reg == `DM_LAST)
                                                           : (eng_cnt_reg == `DM_COPY_LAST);
  assign unit_valid = unit_cfg_reg[`SETUP_UNITS16_BIT] || (unit_sel_reg < 4'hA);
  assign unit_start = unit_base(unit_sel_reg, unit_cfg_reg[`SETUP_HIBASE_BIT]);
  assign viol_clr   = reg_wr && (idx_reg == `REG_STATUS) && hwdata[0];
  assign hreadyout  = (state_reg == dm_map_pkg::ST_IDLE) || (state_reg == dm_map_pkg::ST_RESP);
  assign hresp      = 1'b0;
  assign hrdata     = resp_mem_reg ? {16'h0000, mem_rdata} : hrdata_reg;

  assign reg_rdata =
      (idx_reg == `REG_CTRL)         ? {29'h0, ctrl_reg} :
      (idx_reg == `REG_EXT_SIZE)     ? {30'h0, ext_size_reg} :
      (idx_reg == `REG_STATUS)       ? {30'h0, cleared_reg, viol_reg} :
      (idx_reg == `REG_UNIT_SEL)     ? {16'h0, unit_valid, 1'b0, unit_start} :
      (idx_reg == `REG_UNIT_CFG)     ? {30'h0, unit_cfg_reg} :
      (idx_reg == `REG_PEAK_SCAN)    ? {16'h0, peak_scan_time} :
      (idx_reg == `REG_PRESENT_SCAN) ? {16'h0, present_scan_time} : 32'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer and memory port
  always_comb begin
    state_next    = state_reg;
    hrdata_next   = hrdata_reg;
    resp_mem_next = 1'b0;
    mem_en        = 1'b0;
    mem_we        = 1'b0;
    mem_addr      = word_reg;
    mem_wdata     = hwdata[15:0];
    viol_set      = 1'b0;
    case (state_reg)
      dm_map_pkg::ST_IDLE, dm_map_pkg::ST_RESP: begin
        if (take) begin
          state_next = dm_map_pkg::ST_ACC;
        end else if (start_copy_reg && (ext_size_reg != 2'h0)) begin
          state_next = dm_map_pkg::ST_COPY_RD;
        end else begin
          state_next = dm_map_pkg::ST_IDLE;
        end
      end
      dm_map_pkg::ST_ACC: begin
        hrdata_next = 32'h0;
        state_next  = dm_map_pkg::ST_RESP;
        case (kind_reg)
          dm_map_pkg::K_REG: begin
            hrdata_next = write_reg ? 32'h0 : reg_rdata;
            if (write_reg && (idx_reg == `REG_CTRL)) begin
              if (hwdata[`CTRL_CLEAR_BIT]) begin
                state_next = dm_map_pkg::ST_CLEAR;
              end else if (hwdata[`CTRL_COPY_BIT] && (ext_size_reg != 2'h0)) begin
                state_next = dm_map_pkg::ST_COPY_RD;
              end
            end
            if (write_reg && (idx_reg == `REG_EXT_SIZE) && !cleared_reg) begin
              viol_set = 1'b1;
            end
          end
          dm_map_pkg::K_DATA: begin
            if (bitop) begin
              viol_set = 1'b1;
            end else if (write_reg) begin
              mem_en   = wr_ok(word_reg, ext_top, tool, hwdata[15:0]);
              mem_we   = mem_en;
              viol_set = !mem_en;
            end else begin
              mem_en        = rd_ok(word_reg, ext_top);
              resp_mem_next = mem_en;
              viol_set      = !mem_en;
            end
          end
          default: begin
            if (op_ok) begin
              mem_en     = 1'b1;
              state_next = dm_map_pkg::ST_IND;
            end else begin
              viol_set = 1'b1;
            end
          end
        endcase
      end
      dm_map_pkg::ST_IND: begin
        mem_addr   = target;
        mem_wdata  = wdata_reg;
        state_next = dm_map_pkg::ST_RESP;
        if (!target_ok) begin
          viol_set = 1'b1;
        end else if (write_reg) begin
          mem_en   = wr_ok(target, ext_top, tool, wdata_reg);
          mem_we   = mem_en;
          viol_set = !mem_en;
        end else begin
          mem_en        = 1'b1;
          resp_mem_next = 1'b1;
        end
      end
      dm_map_pkg::ST_CLEAR: begin
        mem_en    = 1'b1;
        mem_we    = 1'b1;
        mem_addr  = eng_cnt_reg;
        mem_wdata = 16'h0000;
        if (eng_last) begin
          state_next = dm_map_pkg::ST_RESP;
        end
      end
      dm_map_pkg::ST_COPY_RD: begin
        mem_en     = 1'b1;
        mem_addr   = `DM_EXT_BASE + eng_cnt_reg;
        state_next = dm_map_pkg::ST_COPY_WR;
      end
      dm_map_pkg::ST_COPY_WR: begin
        mem_en    = 1'b1;
        mem_we    = 1'b1;
        mem_addr  = `DM_DEF_BASE + eng_cnt_reg;
        mem_wdata = mem_rdata;
        if (eng_last) begin
          state_next = ret_bus_reg ? dm_map_pkg::ST_RESP : dm_map_pkg::ST_IDLE;
        end else begin
          state_next = dm_map_pkg::ST_COPY_RD;
        end
      end
      default: begin
        state_next = dm_map_pkg::ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus capture and sequencer registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg    <= dm_map_pkg::ST_IDLE;
      kind_reg     <= dm_map_pkg::K_REG;
      word_reg     <= 14'h0000;
      idx_reg      <= 8'h00;
      write_reg    <= 1'b0;
      wdata_reg    <= 16'h0000;
      hrdata_reg   <= 32'h0;
      resp_mem_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      hrdata_reg   <= hrdata_next;
      resp_mem_reg <= resp_mem_next;
      if (state_reg == dm_map_pkg::ST_ACC) begin
        wdata_reg <= hwdata[15:0];
      end
      if (take && hreadyout) begin
        kind_reg  <= (haddr[17:16] == `WIN_DATA)     ? dm_map_pkg::K_DATA :
                     (haddr[17:16] == `WIN_INDIRECT) ? dm_map_pkg::K_IND : dm_map_pkg::K_REG;
        word_reg  <= haddr[15:2];
        idx_reg   <= (haddr[17:16] == `WIN_REGS && haddr[15:10] == 6'h00) ? haddr[9:2] : 8'hFF;
        write_reg <= hwrite;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // clear and copy engines
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eng_cnt_reg    <= 14'h0000;
      ret_bus_reg    <= 1'b0;
      start_copy_reg <= 1'b0;
    end else begin
      if (state_next != state_reg && state_reg == dm_map_pkg::ST_ACC) begin
        ret_bus_reg <= 1'b1;
      end else if (state_reg == dm_map_pkg::ST_IDLE || state_reg == dm_map_pkg::ST_RESP) begin
        ret_bus_reg <= 1'b0;
      end
      if ((state_reg == dm_map_pkg::ST_CLEAR || state_reg == dm_map_pkg::ST_COPY_WR)) begin
        eng_cnt_reg <= eng_last ? 14'h0000 : eng_cnt_reg + 14'h0001;
      end
      // start-up copy waits for a quiet bus
      if (run_start && ctrl_reg[`CTRL_STARTCP_BIT]) begin
        start_copy_reg <= 1'b1;
      end else if (state_next == dm_map_pkg::ST_COPY_RD || ext_size_reg == 2'h0) begin
        start_copy_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg     <= `CTRL_RESET;
      ext_size_reg <= `EXT_SIZE_RESET;
      unit_sel_reg <= 4'h0;
      unit_cfg_reg <= 2'h0;
      viol_reg     <= 1'b0;
      cleared_reg  <= 1'b0;
    end else begin
      if (reg_wr && idx_reg == `REG_CTRL) begin
        ctrl_reg <= hwdata[2:0];
      end
      if (reg_wr && idx_reg == `REG_EXT_SIZE && cleared_reg) begin
        ext_size_reg <= hwdata[1:0];
      end
      if (reg_wr && idx_reg == `REG_UNIT_SEL) begin
        unit_sel_reg <= hwdata[3:0];
      end
      // setup word shadow follows every store into it, clear included
      if (mem_we && mem_addr == `DM_SETUP_UNITS) begin
        unit_cfg_reg <= {mem_wdata[`SETUP_HIBASE_BIT], mem_wdata[`SETUP_UNITS16_BIT]};
      end
      // a refusal in the same cycle as the clear still shows
      if (viol_set) begin
        viol_reg <= 1'b1;
      end else if (viol_clr) begin
        viol_reg <= 1'b0;
      end
      if (state_reg == dm_map_pkg::ST_CLEAR && eng_last) begin
        cleared_reg <= 1'b1;
      end else if (mem_we && state_reg != dm_map_pkg::ST_CLEAR) begin
        cleared_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // storage and scan time
  // extended words share the store with the rest, so they go wherever it goes
  data_word_store #(
    .DEPTH (DEPTH),
    .AW    (14),
    .DW    (16)
  ) u_store (
    .hclk  (hclk),
    .en    (mem_en),
    .we    (mem_we),
    .addr  (mem_addr),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  scan_time_bcd #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_scan (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .run_start   (run_start),
    .scan_end    (scan_end),
    .peak_bcd    (peak_scan_time),
    .present_bcd (present_scan_time)
  );
endmodule

// ===== tb/data_memory_map_access_checker.sv
// port-level checks on the data-word map
`timescale 1ns/10ps
module data_memory_map_access_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp
);
  logic        take;
  logic        rd;
  logic [13:0] word;
  assign take = hsel && htrans[1] && hready && hreadyout;
  assign rd   = take && !hwrite;
  assign word = haddr[15:2];
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////
  a_resp_okay: assert property (
    hresp == 1'b0) else $error("response not okay");
  a_data_one_wait: assert property (
    take && haddr[17:16] == 2'h1 |=> !hreadyout ##1 hreadyout)
    else $error("direct access wait count wrong");
  a_ind_two_waits: assert property (
    take && haddr[17:16] == 2'h2 && word < 14'h1A00 |=> !hreadyout [*2] ##1 hreadyout)
    else $error("indirect access wait count wrong");
  a_gap_reads_zero: assert property (
    rd && haddr[17:16] == 2'h1 && word >= 14'h1A00 && word < 14'h1B58 |-> ##2 hrdata == 32'h0)
    else $error("gap word returned data");
  a_far_reads_zero: assert property (
    rd && haddr[17:16] == 2'h1 && word > 14'h270F |-> ##2 hrdata == 32'h0)
    else $error("word beyond 9999 returned data");
  a_upper_half_zero: assert property (
    rd && haddr[17:16] == 2'h1 |-> ##2 hrdata[31:16] == 16'h0)
    else $error("data word wider than 16 bits");
  // each digit nine at most, so a binary count leaking out shows at once
  a_scan_bcd_digits: assert property (
    rd && haddr[17:16] == 2'h0 && haddr[15:10] == 6'h0 && haddr[9:3] == 7'h0D
    |-> ##2 hrdata[31:16] == 16'h0 && hrdata[15:12] <= 4'h9 && hrdata[11:8] <= 4'h9
        && hrdata[7:4] <= 4'h9 && hrdata[3:0] <= 4'h9)
    else $error("scan word not bcd");
  a_ind_ext_zero: assert property (
    rd && haddr[17:16] == 2'h2 && word >= 14'h1A00
    |=> !hreadyout ##[1:2] (hreadyout && hrdata == 32'h0))
    else $error("indirect through high word returned data");
endmodule
bind data_memory_map_access data_memory_map_access_checker data_memory_map_access_checker_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

// ===== tb/scan_source_model.sv
// scan-cycle source standing in for the controller program
`timescale 1ns/10ps
module scan_source_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        restart,
  input  wire logic [15:0] scan_len,
  output logic             run_start,
  output logic             scan_end
);
  logic [15:0] cnt_reg;
  // restart opens the first scan afresh, so no end pulse rides on it
  assign run_start = restart;
  assign scan_end  = hresetn && !restart && cnt_reg == scan_len;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      cnt_reg <= 16'h0001;
    else if (restart || scan_end)
      cnt_reg <= 16'h0001;
    else
      cnt_reg <= cnt_reg + 16'h0001;
  end
endmodule

// ===== tb/tb.sv
// self-checking bench for the data-word map
`timescale 1ns/10ps
module tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        run_start;
  logic        scan_end;
  logic        restart = 1'b0;
  logic [15:0] scan_len = 16'h0003;
  logic [31:0] q;
  logic [31:0] r;
  int          errors = 0;
  int          compares = 0;
  int          seed = 62566;
  int          k;
  int          pk;
  int          ks[4] = '{7, 3, 0, 12};
  int          pw[4] = '{6031, 6144, 6655, 7005};
  int          ok[4] = '{0, 6143, 6100, 0};
  always #2 hclk = ~hclk;
  data_memory_map_access #(.TICK_CYCLES(4)) data_memory_map_access_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .run_start(run_start),
    .scan_end(scan_end));
  scan_source_model scan_source_model_inst (
    .hclk(hclk), .hresetn(hresetn), .restart(restart), .scan_len(scan_len),
    .run_start(run_start), .scan_end(scan_end));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] dw(input int w);
    return 32'h10000 + 32'(w) * 4;
  endfunction
  function automatic logic [31:0] bcd(input int v);
    return {16'h0, 4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
  endfunction
  // ready and read data taken at the rising edge, before the design's flops move
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    logic rdy;
    int   n;
    n = 0;
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    for (int ph = 0; ph < 2; ph++) begin
      do begin
        @(posedge hclk);
        rdy = hreadyout;
        q = hrdata;
        n++;
      end while (rdy !== 1'b1 && n < 20000);
      if (rdy !== 1'b1)
        errors++;
      htrans <= 2'h0;
      hwdata <= d;
    end
  endtask
  task automatic rc(input string nm, input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    compares++;
    if (q !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, q);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    errors++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rc("peak", 32'h68, 32'h0);
    rc("present", 32'h6C, 32'h0);
    xfer(1'b1, 32'h4, 32'h1);
    rc("size_uncleared", 32'h4, 32'h0);
    rc("status_refusal", 32'h8, 32'h1);
    xfer(1'b1, 32'h0, 32'h9);
    xfer(1'b1, 32'h4, 32'h1);
    rc("size", 32'h4, 32'h1);
    xfer(1'b1, dw(7000), 32'h1234);
    xfer(1'b1, dw(7999), 32'h5678);
    rc("ext_top", dw(7999), 32'h5678);
    rc("ext_above", dw(8000), 32'h0);
    rc("gap_word", dw(6800), 32'h0);
    rc("far_word", dw(16383), 32'h0);
    rc("ind_high_operand", dw(7000) + 32'h10000, 32'h0);
    xfer(1'b1, 32'h0, 32'h11);
    rc("copy", dw(1000), 32'h1234);
    r = $random(seed);
    xfer(1'b1, dw(100), 32'h7000);
    rc("ind_ext", dw(100) + 32'h10000, 32'h0);
    xfer(1'b1, dw(100), 32'h0324);
    xfer(1'b1, dw(324), {16'h0, r[15:0]});
    rc("ind_read", dw(100) + 32'h10000, {16'h0, r[15:0]});
    xfer(1'b1, dw(100) + 32'h10000, {16'h0, r[31:16]});
    rc("ind_write", dw(324), {16'h0, r[31:16]});
    foreach (pw[i]) begin
      xfer(1'b1, 32'h0, 32'h1);
      xfer(1'b1, dw(pw[i]), 32'h00A5 + i);
      xfer(1'b1, 32'h0, 32'h0);
      xfer(1'b1, dw(pw[i]), 32'h0F0F);
      rc("program_write_refused", dw(pw[i]), 32'h00A5 + i);
    end
    ok[3] = {$random(seed)} % 6000;
    foreach (ok[i]) begin
      r = $random(seed);
      xfer(1'b1, dw(ok[i]), r);
      rc("program_write", dw(ok[i]), {16'h0, r[15:0]});
    end
    xfer(1'b1, dw(6000), 32'hA);
    xfer(1'b1, dw(6000), 32'hB);
    rc("history_pointer", dw(6000), 32'hA);
    xfer(1'b1, 32'h0, 32'h2);
    rc("bit_operand", dw(6000), 32'h0);
    xfer(1'b1, 32'h0, 32'h1);
    for (int c = 0; c < 2; c++) begin
      xfer(1'b1, dw(6602), c * 3);
      for (int u = 0; u < 16; u++) begin
        xfer(1'b1, 32'hC, u);
        rc("unit_block", 32'hC, {16'h0, c == 1 || u < 10, 1'b0,
           14'(1000 + 6000 * c + 100 * u)});
      end
    end
    // copy on run start: each restart below moves the extended words down
    xfer(1'b1, dw(7000), 32'h4321);
    xfer(1'b1, 32'h0, 32'h5);
    // lengths of 4k+2 keep the tick count clear of rounding at either end
    for (int i = 0; i < 6; i++) begin
      k = (i < 4) ? ks[i] : {$random(seed)} % 30;
      @(negedge hclk iff scan_end);
      @(posedge hclk);
      scan_len <= 16'(4 * k + 2);
      if (i == 0 || i == 5) begin
        restart <= 1'b1;
        pk = 0;
        @(posedge hclk);
        restart <= 1'b0;
      end
      pk = (k > pk) ? k : pk;
      @(negedge hclk iff scan_end);
      rc("present", 32'h6C, bcd(k));
      rc("peak", 32'h68, bcd(pk));
    end
    rc("start_copy", dw(1000), 32'h4321);
    print_verdict();
  end
endmodule
